// >>> dv/montgomery_square_unit_tb.sv
// Purpose: self-checking bench of the squaring unit
// Assumes: register file model answers reads one cycle later
// Notes:   expected squares come from a wide reference in the bench
`timescale 1ns/1ps
`include "msq_cfg.svh"
module montgomery_square_unit_tb;
  logic             sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic             window_restore_mark, hw_error, busy;
  logic [7:0]       wb_adr_i;
  logic [31:0]      wb_dat_i, wb_dat_o, rd_val;
  logic [3:0]       wb_sel_i;
  logic [63:0]      rf_rdata;
  msq_pkg::issue_t  issue;
  msq_pkg::trap_t   trap;
  msq_pkg::cc_upd_t cc_upd;
  msq_pkg::rf_req_t rf_req;
  int               bad_count, checks, cyc_n;

  montgomery_square_unit montgomery_square_unit_i (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .issue,
    .window_restore_mark, .hw_error, .trap, .cc_upd, .busy, .rf_req, .rf_rdata);
  rf_model rf_model_i (.sys_clk, .rf_req, .rf_rdata);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ------
  // helpers
  // ------
  task automatic check(string what, logic [191:0] seen, logic [191:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb_xfer(logic we, logic [7:0] adr, logic [31:0] dat, logic [3:0] sel);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd_val = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    check("wb ack", wb_ack_o, 1'b1);
  endtask

  task automatic send(logic [4:0] rd, logic [4:0] fs, logic [4:0] len);
    @(posedge sys_clk);
    issue <= '{1'b1, rd, fs, len};
    @(posedge sys_clk);
    issue.valid <= 1'b0;
    // trap and busy were launched at the previous edge and are read here
    @(posedge sys_clk);
  endtask

  task automatic exp_trap(msq_pkg::trap_kind_t k, logic oth, logic [2:0] idx, logic [4:0] current_window_pointer);
    check("trap valid", trap.valid, 1'b1);
    check("trap kind", trap.kind, k);
    if (k == msq_pkg::TRAP_FILL) begin
      check("fill other", trap.fill_other, oth);
      check("fill index", trap.fill_index, idx);
      check("new cwp", trap.new_cwp, current_window_pointer);
    end
  endtask

  task automatic restore_mark();
    @(posedge sys_clk);
    window_restore_mark <= 1'b1;
    @(posedge sys_clk);
    window_restore_mark <= 1'b0;
  endtask

  function automatic logic [191:0] w(logic [191:0] v, int k);
    return 192'(v[64*k +: 64]);
  endfunction

  function automatic logic [63:0] inv_of(logic [63:0] n0);
    logic [63:0] v;
    v = n0;
    repeat (6) v = v * (64'h2 - n0 * v);
    return -v;
  endfunction

  function automatic logic [191:0] ref_sqr(logic [191:0] a, logic [191:0] n, int l);
    logic [191:0] acc, x, mv, mask;
    acc = '0;
    x = '0;
    mv = '0;
    mask = (192'h1 << (64 * (l + 1))) - 192'h1;
    for (int i = 0; i <= 2 * l + 1; i++) begin
      for (int j = (i > l) ? i - l : 0; 2 * j < i; j++)
        acc += 192'h2 * w(a, j) * w(a, i - j);
      if (i % 2 == 0)
        acc += w(a, i / 2) * w(a, i / 2);
      for (int j = (i > l) ? i - l : 0; j < i && j <= l; j++)
        acc += w(mv, j) * w(n, i - j);
      if (i <= l) begin
        mv[64*i +: 64] = acc[63:0] * inv_of(n[63:0]);
        acc += w(mv, i) * w(n, 0);
      end else begin
        x[64*(i-l-1) +: 64] = acc[63:0];
      end
      acc = acc >> 64;
    end
    if (acc[0] || x >= n)
      x = (x - n) & mask;
    return x;
  endfunction

  // ------
  // scenarios
  // ------
  task automatic t_regs();
    wb_xfer(1'b0, `ADR_CTRL, 32'h0, 4'hf);
    check("ctrl reset", rd_val, `CTRL_RST);
    wb_xfer(1'b1, `ADR_CTRL, 32'h0000_000f, 4'h0);
    wb_xfer(1'b0, `ADR_CTRL, 32'h0, 4'hf);
    check("ctrl sel gated", rd_val, `CTRL_RST);
    wb_xfer(1'b1, 8'h0c, 32'hffff_ffff, 4'hf);
    wb_xfer(1'b0, 8'h0c, 32'h0, 4'hf);
    check("unmapped", rd_val, 32'h0);
    wb_xfer(1'b0, `ADR_STAT, 32'h0, 4'hf);
    check("stat idle", rd_val, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_traps();
    send(5'h0, 5'h0, 5'h0);
    exp_trap(msq_pkg::TRAP_FEATURE, 1'b0, 3'h0, 5'h0);
    send(5'h1, 5'h0, 5'h0);
    exp_trap(msq_pkg::TRAP_ILLEGAL, 1'b0, 3'h0, 5'h0);
    wb_xfer(1'b1, `ADR_WIN, 32'h0000_0006, 4'hf);
    wb_xfer(1'b1, `ADR_CTRL, 32'h0000_000f, 4'hf);
    send(5'h0, 5'h3, 5'h1f);
    exp_trap(msq_pkg::TRAP_ILLEGAL, 1'b0, 3'h0, 5'h0);
    for (int b = 1; b < 4; b++) begin
      wb_xfer(1'b1, `ADR_CTRL, 32'h0000_000f ^ (32'h1 << b), 4'hf);
      send(5'h0, 5'h0, 5'h0);
      exp_trap(msq_pkg::TRAP_FPU_OFF, 1'b0, 3'h0, 5'h0);
    end
    check("no rf writes", rf_model_i.wr_count, 0);
    $display("test traps done");
  endtask

  task automatic t_fill();
    wb_xfer(1'b1, `ADR_CTRL, 32'h0000_000f, 4'hf);
    wb_xfer(1'b1, `ADR_WIN, 32'h2b05_0002, 4'hf);
    send(5'h0, 5'h0, 5'h0);
    exp_trap(msq_pkg::TRAP_FILL, 1'b0, 3'h3, 5'h02);
    restore_mark();
    wb_xfer(1'b0, `ADR_WIN, 32'h0, 4'hf);
    check("win window_restore_mark", rd_val, 32'h2b02_0003);
    send(5'h0, 5'h0, 5'h0);
    exp_trap(msq_pkg::TRAP_FILL, 1'b0, 3'h3, 5'h06);
    wb_xfer(1'b1, `ADR_WIN, 32'h2b01_0104, 4'hf);
    send(5'h0, 5'h0, 5'h0);
    exp_trap(msq_pkg::TRAP_FILL, 1'b1, 3'h5, 5'h04);
    restore_mark();
    wb_xfer(1'b0, `ADR_WIN, 32'h0, 4'hf);
    check("win other", rd_val, 32'h2b04_0005);
    check("no rf writes", rf_model_i.wr_count, 0);
    $display("test fill done");
  endtask

  task automatic t_op(int l, logic err);
    logic [191:0] a, n, x, mask;
    int           w0, k;
    mask = (192'h1 << (64 * (l + 1))) - 192'h1;
    a = 192'h0fed_0000_1111_2222_0123_4567_89ab_cdef_5a5a_5a5a_5a5a_5a5a & mask;
    n = 192'hf123_4567_89ab_cdef_8765_4321_0fed_cba9_d1e2_f3a4_b5c6_d7e9 & mask;
    for (k = 0; k < 3; k++) begin
      rf_model_i.mem[`RF_A_BASE + k] = a[64*k +: 64];
      rf_model_i.mem[`RF_N_BASE + k] = n[64*k +: 64];
      rf_model_i.mem[`RF_X_BASE + k] = 64'h5eed_5eed_5eed_5eed;
    end
    rf_model_i.mem[`RF_NPRIME] = inv_of(n[63:0]);
    w0 = rf_model_i.wr_count;
    wb_xfer(1'b1, `ADR_WIN, 32'h0000_0006, 4'hf);
    send(5'h0, 5'h0, 5'(l));
    check("accepted", {trap.valid, busy}, 2'b01);
    if (err) begin
      @(posedge sys_clk);
      hw_error <= 1'b1;
      @(posedge sys_clk);
      hw_error <= 1'b0;
    end
    k = 0;
    while (cc_upd.wr !== 1'b1 && k < 20000) begin
      @(posedge sys_clk);
      k++;
    end
    check("done", cc_upd.wr, 1'b1);
    check("cc flag", cc_upd.error_condition_flag, err);
    x = ref_sqr(a, n, l);
    for (k = 0; k < 3; k++)
      check("result", rf_model_i.mem[`RF_X_BASE + k],
            (k <= l) ? x[64*k +: 64] : 64'h5eed_5eed_5eed_5eed);
    check("rf writes", rf_model_i.wr_count - w0, l + 1);
    wb_xfer(1'b0, `ADR_STAT, 32'h0, 4'hf);
    check("stat", rd_val, {30'h0, err, 1'b0});
    $display("test op length %0d done", l);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    bad_count = 0;
    checks = 0;
    cyc_n = 0;
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    issue = '0;
    window_restore_mark = 1'b0;
    hw_error = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_traps();
    t_fill();
    t_op(0, 1'b0);
    t_op(1, 1'b1);
    t_op(2, 1'b0);
    report_and_stop();
  end
endmodule

// >>> dv/rf_model.sv
// Purpose: integer register file seen by the squaring unit
// Assumes: read data is wanted the cycle after rd_en
// Notes:   idle read data toggles so a late sample never matches
`timescale 1ns/1ps
module rf_model (
  // clock
  input  wire logic              sys_clk,
  // register file port
  input  wire msq_pkg::rf_req_t  rf_req,
  output logic [63:0]            rf_rdata
);
  logic [63:0] mem [0:127];
  int          wr_count;

  initial begin
    wr_count = 0;
    rf_rdata = 64'h0;
  end

  // ------
  // read and write
  // ------
  always @(posedge sys_clk) begin
    if (rf_req.rd_en) begin
      rf_rdata <= mem[rf_req.addr[6:0]];
    end else begin
      rf_rdata <= ~rf_rdata;
    end
    if (rf_req.wr_en) begin
      mem[rf_req.addr[6:0]] <= rf_req.wdata;
      wr_count <= wr_count + 1;
    end
  end
endmodule

// >>> pkg/msq_cfg.svh
// Purpose: offsets, field positions and fixed values of the squaring unit
// Assumes: byte addresses on a 32-bit wishbone data path
// Notes:   definitions only
`ifndef MSQ_CFG_SVH
`define MSQ_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADR_CTRL   8'h00
`define ADR_WIN    8'h04
`define ADR_STAT   8'h08
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_FEAT  0
`define CTRL_FPEN  1
`define CTRL_SFPEN 2
`define CTRL_FPU   3
`define WIN_CR     0
`define WIN_OW     8
`define WIN_CWP    16
`define WIN_WS     24
// ----------------------------------------
// reset values and fixed places
// ----------------------------------------
`define CTRL_RST   32'h0000_0000
`define WIN_TOTAL  6'h08
`define RF_A_BASE  9'h000
`define RF_N_BASE  9'h020
`define RF_NPRIME  9'h040
`define RF_X_BASE  9'h060
`endif

// >>> pkg/msq_pkg.sv
// Purpose: types shared by the squaring unit and its bench
// Assumes: nothing
// Notes:   constants live in msq_cfg.svh
package msq_pkg;
  typedef struct packed {
    logic       valid;
    logic [4:0] rd;
    logic [4:0] first_src_field;
    logic [4:0] length_field;
  } issue_t;
  typedef enum logic [2:0] {
    TRAP_NONE    = 3'h0,
    TRAP_ILLEGAL = 3'h1,
    TRAP_FEATURE = 3'h2,
    TRAP_FPU_OFF = 3'h3,
    TRAP_FILL    = 3'h4
  } trap_kind_t;
  typedef struct packed {
    logic       valid;
    trap_kind_t kind;
    logic       fill_other;
    logic [2:0] fill_index;
    logic [4:0] new_cwp;
  } trap_t;
  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [8:0]  addr;
    logic [63:0] wdata;
  } rf_req_t;
  typedef struct packed {
    logic wr;
    logic error_condition_flag;
  } cc_upd_t;
  typedef enum logic [11:0] {
    ST_IDLE  = 12'h001,
    ST_LOAD  = 12'h002,
    ST_CROSS = 12'h004,
    ST_EVEN  = 12'h008,
    ST_MN    = 12'h010,
    ST_MCALC = 12'h020,
    ST_MADD  = 12'h040,
    ST_SHIFT = 12'h080,
    ST_CMP   = 12'h100,
    ST_SUB   = 12'h200,
    ST_STORE = 12'h400,
    ST_DONE  = 12'h800
  } state_t;
endpackage

// >>> rtl/montgomery_square_unit.sv
// Purpose: Montgomery squaring execution unit with its trap checks
// Assumes: register file read data arrives the cycle after the request
// Notes:   one 64x64 multiply per cycle, word-serial accumulator
`timescale 1ns/1ps
`include "msq_cfg.svh"
// Contract
// - the operand spans length_field plus one 64-bit words, up to 32.
// - operand and result places are fixed and only used words are written.
// - completion updates error_condition_flag with any hardware error seen.
// - phase one adds doubled cross products, the even square and M*N terms.
// - M[I] is low(acc) times the inverse word, then M[I]*N[0] is added, shift.
// - phase two accumulates the rest, stores X[I-length-1] and shifts.
// - a nonzero final carry subtracts the modulus with borrow.
// - with zero carry the modulus is subtracted only if result >= modulus.
// - a nonzero rd or first_src_field raises the illegal trap.
// - a clear feature_present_bit raises the feature-absent trap.
// - fpu off or absent raises fpu_off_trap.
// - a fill trap is raised unless restorable count is total minus two.
// - the fill trap sets the window pointer to old minus count minus one.
// - the fill vector comes from other_window_count and window_state_reg.
// - a restore mark raises the restorable count, lowers a nonzero other count, and retry re-checks the fill.
module montgomery_square_unit (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // pipeline
  input  wire msq_pkg::issue_t  issue,
  input  wire logic             window_restore_mark,
  input  wire logic             hw_error,
  output msq_pkg::trap_t        trap,
  output msq_pkg::cc_upd_t      cc_upd,
  output logic                  busy,
  // integer register file
  output msq_pkg::rf_req_t      rf_req,
  input  wire logic [63:0]      rf_rdata
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  msq_pkg::state_t st_reg;
  logic [31:0]  ctrl_reg;
  logic [4:0]   cr_reg;
  logic [4:0]   ow_reg;
  logic [4:0]   cwp_reg;
  logic [5:0]   ws_reg;
  logic         ack_reg;
  logic         flag_reg;
  logic         err_reg;
  logic [4:0]   len_reg;
  logic [5:0]   col_reg;
  logic [5:0]   j_reg;
  logic [6:0]   ld_reg;
  logic [6:0]   iss_idx_reg;
  logic [6:0]   cap_idx_reg;
  logic         cap_vld_reg;
  logic         carry_reg;
  logic         borrow_reg;
  logic [135:0] acc_reg;
  logic [63:0]  np_reg;
  logic [63:0]  a_mem [0:31];
  logic [63:0]  n_mem [0:31];
  logic [63:0]  m_mem [0:31];
  logic [63:0]  x_mem [0:31];

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  // first word index of a column
  function automatic logic [5:0] jlo_f(input logic [5:0] c, input logic [4:0] l);
    return (c <= {1'b0, l}) ? 6'h00 : 6'(c - {1'b0, l});
  endfunction

  // ----------------------------------------
  // issue checks
  // ----------------------------------------
  wire       idle      = st_reg == msq_pkg::ST_IDLE;
  wire       go        = issue.valid && idle;
  wire       bad_field = issue.rd != 5'h00 || issue.first_src_field != 5'h00;
  wire       feat      = ctrl_reg[`CTRL_FEAT];
  wire       fp_off    = !ctrl_reg[`CTRL_FPEN] || !ctrl_reg[`CTRL_SFPEN]
                         || !ctrl_reg[`CTRL_FPU];
  wire       need_fill = {1'b0, cr_reg} != 6'(`WIN_TOTAL - 6'h02);
  wire [5:0] cwp_sum   = 6'({1'b0, cwp_reg} + 6'(2 * `WIN_TOTAL) - {1'b0, cr_reg} - 6'h01);
  wire [4:0] fill_cwp  = 5'(cwp_sum % `WIN_TOTAL);
  wire       fill_oth  = ow_reg != 5'h00;
  wire [2:0] fill_idx  = fill_oth ? ws_reg[5:3] : ws_reg[2:0];
  msq_pkg::trap_kind_t kind_w;
  assign kind_w = bad_field ? msq_pkg::TRAP_ILLEGAL :
                  !feat     ? msq_pkg::TRAP_FEATURE :
                  fp_off    ? msq_pkg::TRAP_FPU_OFF :
                  need_fill ? msq_pkg::TRAP_FILL    :
                  msq_pkg::TRAP_NONE;
  wire launch = go && kind_w == msq_pkg::TRAP_NONE;
  assign busy = !idle;

  // ----------------------------------------
  // datapath decode
  // ----------------------------------------
  wire [5:0] len6     = {1'b0, len_reg};
  wire       ph1      = col_reg <= len6;
  wire [5:0] cross_hi = 6'(col_reg - 6'h01) >> 1;
  wire       cross_ok = col_reg != 6'h00 && j_reg <= cross_hi;
  wire       mn_ok    = ph1 ? j_reg < col_reg : j_reg <= len6;
  wire [4:0] jj       = j_reg[4:0];
  wire [4:0] oj       = 5'(col_reg - j_reg);
  wire [4:0] half     = col_reg[5:1];
  wire       s_cross  = st_reg == msq_pkg::ST_CROSS;
  wire       s_even   = st_reg == msq_pkg::ST_EVEN;
  wire       s_mn     = st_reg == msq_pkg::ST_MN;
  wire       s_mcalc  = st_reg == msq_pkg::ST_MCALC;
  wire [63:0] op_a = s_cross ? a_mem[jj] : s_even ? a_mem[half] :
                     s_mn ? m_mem[jj] : s_mcalc ? acc_reg[63:0] : m_mem[col_reg[4:0]];
  wire [63:0] op_b = s_cross ? a_mem[oj] : s_even ? a_mem[half] :
                     s_mn ? n_mem[oj] : s_mcalc ? np_reg : n_mem[0];
  wire [127:0] prod = op_a * op_b;
  wire [135:0] term = s_cross ? {7'h00, prod, 1'b0} : {8'h00, prod};
  wire add_en = (s_cross && cross_ok) || (s_even && !col_reg[0]) || (s_mn && mn_ok)
                || st_reg == msq_pkg::ST_MADD;
  wire [64:0] diff = {1'b0, x_mem[jj]} - {1'b0, n_mem[jj]} - {64'h0, borrow_reg};
  wire [6:0]  ld_last = 7'({len_reg, 1'b0}) + 7'h02;
  wire [8:0]  ld_addr = ld_reg <= {2'b00, len_reg} ? `RF_A_BASE + 9'(ld_reg) :
                        ld_reg < ld_last ? `RF_N_BASE + 9'(ld_reg - {2'b00, len_reg} - 7'h01) :
                        `RF_NPRIME;

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  wire        wb_req = wb_cyc_i && wb_stb_i;
  wire        wb_wr  = wb_req && wb_we_i && ack_reg;
  wire [31:0] win_w  = {2'b00, ws_reg, 3'b000, cwp_reg, 3'b000, ow_reg, 3'b000, cr_reg};
  wire [31:0] stat_w = {30'h0000_0000, flag_reg, busy};
  wire [31:0] rd_w   = wb_adr_i == `ADR_CTRL ? ctrl_reg :
                       wb_adr_i == `ADR_WIN  ? win_w :
                       wb_adr_i == `ADR_STAT ? stat_w : 32'h0000_0000;
  wire [31:0] win_n  = merge(win_w, wb_dat_i, wb_sel_i);
  assign wb_ack_o = ack_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= `CTRL_RST;
    end else begin
      ack_reg  <= wb_req && !ack_reg;
      wb_dat_o <= rd_w;
      if (wb_wr && wb_adr_i == `ADR_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // window registers: hardware updates win over software writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cr_reg  <= 5'h00;
      ow_reg  <= 5'h00;
      cwp_reg <= 5'h00;
      ws_reg  <= 6'h00;
    end else begin
      if (wb_wr && wb_adr_i == `ADR_WIN) begin
        cr_reg  <= win_n[`WIN_CR +: 5];
        ow_reg  <= win_n[`WIN_OW +: 5];
        cwp_reg <= win_n[`WIN_CWP +: 5];
        ws_reg  <= win_n[`WIN_WS +: 6];
      end
      if (window_restore_mark) begin
        cr_reg <= 5'(cr_reg + 5'h01);
        if (fill_oth) begin
          ow_reg <= 5'(ow_reg - 5'h01);
        end
      end
      if (go && kind_w == msq_pkg::TRAP_FILL) begin
        cwp_reg <= fill_cwp;
      end
    end
  end

  // ----------------------------------------
  // trap and condition code outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trap     <= '0;
      cc_upd   <= '0;
      flag_reg <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      trap <= {go && kind_w != msq_pkg::TRAP_NONE, kind_w, fill_oth, fill_idx,
               fill_cwp};
      cc_upd.wr <= st_reg == msq_pkg::ST_DONE;
      cc_upd.error_condition_flag <= err_reg || hw_error;
      if (st_reg == msq_pkg::ST_DONE) begin
        flag_reg <= err_reg || hw_error;
      end
      if (launch) begin
        err_reg <= 1'b0;
      end else if (busy && hw_error) begin
        err_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // operand load and result store
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rf_req      <= '0;
      ld_reg      <= 7'h00;
      iss_idx_reg <= 7'h00;
      cap_idx_reg <= 7'h00;
      cap_vld_reg <= 1'b0;
    end else begin
      rf_req.rd_en <= 1'b0;
      rf_req.wr_en <= 1'b0;
      cap_vld_reg  <= rf_req.rd_en;
      cap_idx_reg  <= iss_idx_reg;
      if (launch) begin
        ld_reg <= 7'h00;
      end else if (st_reg == msq_pkg::ST_LOAD && ld_reg <= ld_last) begin
        rf_req.rd_en <= 1'b1;
        rf_req.addr  <= ld_addr;
        iss_idx_reg  <= ld_reg;
        ld_reg       <= 7'(ld_reg + 7'h01);
      end else if (st_reg == msq_pkg::ST_STORE) begin
        rf_req.wr_en <= 1'b1;
        rf_req.addr  <= `RF_X_BASE + {3'b000, j_reg};
        rf_req.wdata <= x_mem[jj];
      end
      if (cap_vld_reg) begin
        if (cap_idx_reg <= {2'b00, len_reg}) begin
          a_mem[cap_idx_reg[4:0]] <= rf_rdata;
        end else if (cap_idx_reg < ld_last) begin
          n_mem[5'(cap_idx_reg - {2'b00, len_reg} - 7'h01)] <= rf_rdata;
        end else begin
          np_reg <= rf_rdata;
        end
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg     <= msq_pkg::ST_IDLE;
      len_reg    <= 5'h00;
      col_reg    <= 6'h00;
      j_reg      <= 6'h00;
      acc_reg    <= '0;
      carry_reg  <= 1'b0;
      borrow_reg <= 1'b0;
    end else begin
      if (add_en) begin
        acc_reg <= acc_reg + term;
      end
      unique case (st_reg)
        msq_pkg::ST_IDLE: begin
          if (launch) begin
            len_reg <= issue.length_field;
            st_reg  <= msq_pkg::ST_LOAD;
          end
        end
        msq_pkg::ST_LOAD: begin
          if (cap_vld_reg && cap_idx_reg == ld_last) begin
            col_reg <= 6'h00;
            j_reg   <= 6'h00;
            acc_reg <= '0;
            st_reg  <= msq_pkg::ST_CROSS;
          end
        end
        msq_pkg::ST_CROSS: begin
          j_reg  <= cross_ok ? 6'(j_reg + 6'h01) : j_reg;
          st_reg <= cross_ok ? msq_pkg::ST_CROSS : msq_pkg::ST_EVEN;
        end
        msq_pkg::ST_EVEN: begin
          j_reg  <= jlo_f(col_reg, len_reg);
          st_reg <= msq_pkg::ST_MN;
        end
        msq_pkg::ST_MN: begin
          if (mn_ok) begin
            j_reg <= 6'(j_reg + 6'h01);
          end else begin
            st_reg <= ph1 ? msq_pkg::ST_MCALC : msq_pkg::ST_SHIFT;
          end
        end
        msq_pkg::ST_MCALC: begin
          m_mem[col_reg[4:0]] <= prod[63:0];
          st_reg <= msq_pkg::ST_MADD;
        end
        msq_pkg::ST_MADD: begin
          st_reg <= msq_pkg::ST_SHIFT;
        end
        msq_pkg::ST_SHIFT: begin
          acc_reg <= acc_reg >> 64;
          if (!ph1) begin
            x_mem[5'(col_reg - len6 - 6'h01)] <= acc_reg[63:0];
          end
          if (col_reg == 6'({len_reg, 1'b1})) begin
            carry_reg  <= acc_reg[64];
            borrow_reg <= 1'b0;
            j_reg      <= len6;
            st_reg     <= msq_pkg::ST_CMP;
          end else begin
            col_reg <= 6'(col_reg + 6'h01);
            j_reg   <= jlo_f(6'(col_reg + 6'h01), len_reg);
            st_reg  <= msq_pkg::ST_CROSS;
          end
        end
        msq_pkg::ST_CMP: begin
          if (carry_reg || x_mem[jj] > n_mem[jj] || (x_mem[jj] == n_mem[jj]
              && j_reg == 6'h00)) begin
            j_reg  <= 6'h00;
            st_reg <= msq_pkg::ST_SUB;
          end else if (x_mem[jj] < n_mem[jj]) begin
            j_reg  <= 6'h00;
            st_reg <= msq_pkg::ST_STORE;
          end else begin
            j_reg <= 6'(j_reg - 6'h01);
          end
        end
        msq_pkg::ST_SUB: begin
          x_mem[jj]  <= diff[63:0];
          borrow_reg <= diff[64];
          j_reg      <= j_reg == len6 ? 6'h00 : 6'(j_reg + 6'h01);
          st_reg     <= j_reg == len6 ? msq_pkg::ST_STORE : msq_pkg::ST_SUB;
        end
        msq_pkg::ST_STORE: begin
          j_reg  <= 6'(j_reg + 6'h01);
          st_reg <= j_reg == len6 ? msq_pkg::ST_DONE : msq_pkg::ST_STORE;
        end
        msq_pkg::ST_DONE: begin
          st_reg <= msq_pkg::ST_IDLE;
        end
        default: begin
          st_reg <= msq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_clean;
    go && !bad_field && feat && !fp_off;
  endsequence
  AST_ILLEGAL: assert property (go && bad_field |=> trap.valid
    && trap.kind == msq_pkg::TRAP_ILLEGAL) else $error("illegal trap missing");
  AST_FEATURE: assert property (go && !bad_field && !feat |=>
    trap.kind == msq_pkg::TRAP_FEATURE) else $error("feature trap missing");
  AST_FPU_OFF: assert property (go && !bad_field && feat && fp_off |=>
    trap.kind == msq_pkg::TRAP_FPU_OFF) else $error("fpu off trap missing");
  AST_FILL: assert property (s_clean ##0 need_fill |=> trap.valid
    && trap.kind == msq_pkg::TRAP_FILL && idle) else $error("fill trap missing");
  AST_FILL_CWP: assert property (s_clean ##0 need_fill |=>
    cwp_reg == 5'(($past(cwp_reg) + 8 * `WIN_TOTAL - $past(cr_reg) - 1) % `WIN_TOTAL))
    else $error("fill window pointer wrong");
  AST_FILL_VEC: assert property (trap.valid && trap.kind == msq_pkg::TRAP_FILL |->
    trap.fill_index == (trap.fill_other ? $past(ws_reg[5:3]) : $past(ws_reg[2:0])))
    else $error("fill vector wrong");
  AST_NO_STATE: assert property (go && kind_w != msq_pkg::TRAP_NONE |=>
    idle && !rf_req.wr_en && !cc_upd.wr) else $error("trapped issue changed state");
  AST_LEN: assert property (launch |=> len_reg == $past(issue.length_field)
    && st_reg == msq_pkg::ST_LOAD) else $error("length not taken");
  AST_RESULT_RANGE: assert property (rf_req.wr_en |-> rf_req.addr >= `RF_X_BASE
    && rf_req.addr <= `RF_X_BASE + {4'h0, len_reg}) else $error("write outside result");
  AST_CARRY_SUB: assert property (st_reg == msq_pkg::ST_CMP && carry_reg |=>
    st_reg == msq_pkg::ST_SUB && j_reg == 6'h00) else $error("carry did not subtract");
  AST_CC: assert property (st_reg == msq_pkg::ST_DONE |=> cc_upd.wr &&
    cc_upd.error_condition_flag == flag_reg ##1 !cc_upd.wr) else $error("cc update wrong");
endmodule
